// ### hdl/debug_pkg.sv
// shared constants and carrier types of the debug access block
// assumes a single 25 MHz system clock domain
package debug_pkg;

  // ****************************************
  // test port instructions
  // ****************************************
  localparam int          IR_LEN          = 4;
  localparam logic [3:0]  IR_IDCODE       = 4'h4;
  localparam logic [3:0]  IR_BYPASS       = 4'hF;
  localparam logic [3:0]  IR_BREAK        = 4'h8;
  localparam logic [3:0]  IR_STEP         = 4'h9;
  localparam logic [3:0]  IR_RESUME       = 4'hA;
  localparam logic [3:0]  IR_RESET_VALUE  = IR_IDCODE;
  localparam int          ID_LEN          = 32;
  // identification value is arbitrary
  localparam logic [31:0] ID_VALUE        = 32'h0ABC_0001;
  localparam logic [3:0]  IR_CAPTURE_PAT  = 4'h1;

  // ****************************************
  // breakpoint setup and memory map
  // ****************************************
  localparam int          CODE_AW         = 16;
  localparam int          RAM_AW          = 8;
  localparam logic [1:0]  PINSEL_PRIMARY  = 2'h0;
  localparam logic [1:0]  PINSEL_SEC_A    = 2'h1;
  localparam logic [1:0]  PINSEL_SEC_B    = 2'h2;

  typedef enum logic [3:0] {
    TS_RESET, TS_IDLE, TS_SEL_DR, TS_CAP_DR, TS_SH_DR, TS_EX1_DR, TS_PA_DR, TS_EX2_DR, TS_UP_DR,
    TS_SEL_IR, TS_CAP_IR, TS_SH_IR, TS_EX1_IR, TS_PA_IR, TS_EX2_IR, TS_UP_IR
  } tap_state_t;

  // core debug status and breakpoint setup bundles, both inputs to the block
  typedef struct packed {
    logic [CODE_AW-1:0] fetch_addr;
    logic               fetch_valid;
    logic [RAM_AW-1:0]  ram_addr;
    logic               ram_valid;
    logic               brk_insn;
    logic               step_done;
  } core_dbg_t;

  typedef struct packed {
    logic [CODE_AW-1:0] code_lo;
    logic [CODE_AW-1:0] code_hi;
    logic               code_en;
    logic               code_range;
    logic [RAM_AW-1:0]  ram_lo;
    logic [RAM_AW-1:0]  ram_hi;
    logic               ram_en;
    logic               step_en;
  } brk_cfg_t;

endpackage : debug_pkg

// ### hdl/debug_monitor_jtag_access.sv
// on-chip debug support: test port, break logic and monitor memory steering
// assumes test port pins arrive asynchronous; core bundles are on clk_sys
//
// Function
// [RQ1] instruction 04h selects the identification register onto the data output
// [RQ2] test-logic reset preloads the instruction with identification selection
// [RQ3] identification value is a constant; scan writes never change it
// [RQ4] debug features act only when started in debug start-up mode
// [RQ5] code breakpoints on one fetch address or on an address range
// [RQ6] ram breakpoint on any access inside a configured range
// [RQ7] executed break instruction enters the monitor
// [RQ8] break from test port command or break pin enters the monitor
// [RQ9] single step returns to monitor after each step
// [RQ10] in monitor, fetches go to monitor rom, data to monitor ram
// [RQ11] controller talks to core via debug interface, takes reset and clock
// [RQ12] test port pins mapped to primary or one of two secondary groups
// [RQ13] tool keeps test clock and data input pins as inputs while connected
// [RQ14] break pin sampled at start-up for mode and later for breaks
// [RQ15] identification is 32 bits, captured, shifted least significant bit first
`timescale 1ns/1ns
module debug_monitor_jtag_access
  import debug_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [1:0]  pin_select,
  input  wire logic [2:0]  tck_pins,
  input  wire logic [2:0]  tms_pins,
  input  wire logic [2:0]  tdi_pins,
  output logic      [2:0]  tdo_out,
  output logic      [2:0]  tdo_oe_n,
  input  wire logic        monitor_break_pin,
  input  wire core_dbg_t   core_dbg,
  input  wire brk_cfg_t    brk_cfg,
  output logic             debug_mode,
  output logic             core_halt,
  output logic             in_monitor,
  output logic             sel_monitor_rom,
  output logic             sel_monitor_ram
);

  // ****************************************
  // pin group selection
  // ****************************************
  // group chosen before synchronising; select is static configuration
  wire logic [1:0] grp = (pin_select > PINSEL_SEC_B) ? PINSEL_PRIMARY : pin_select; // [RQ12]
  wire logic       tck_raw = tck_pins[grp];
  wire logic       tms_raw = tms_pins[grp];
  wire logic       tdi_raw = tdi_pins[grp];

  logic [1:0] tck_s_reg;
  logic [1:0] tms_s_reg;
  logic [1:0] tdi_s_reg;
  logic [1:0] brk_s_reg;
  logic       tck_prev_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tck_s_reg    <= '0;
      tms_s_reg    <= '0;
      tdi_s_reg    <= '0;
      brk_s_reg    <= '0;
      tck_prev_reg <= 1'b0;
    end else begin
      tck_s_reg    <= {tck_s_reg[0], tck_raw};
      tms_s_reg    <= {tms_s_reg[0], tms_raw};
      tdi_s_reg    <= {tdi_s_reg[0], tdi_raw};
      brk_s_reg    <= {brk_s_reg[0], monitor_break_pin}; // [RQ14]
      tck_prev_reg <= tck_s_reg[1];
    end
  end

  wire logic tck_rise = tck_s_reg[1] & ~tck_prev_reg;
  wire logic tck_fall = ~tck_s_reg[1] & tck_prev_reg;
  wire logic tms      = tms_s_reg[1];
  wire logic tdi      = tdi_s_reg[1];
  wire logic brk_pin  = brk_s_reg[1];

  // ****************************************
  // test access state machine
  // ****************************************
  tap_state_t tap_reg;
  tap_state_t tap_next;

  always_comb begin
    tap_next = tap_reg;
    case (tap_reg)
      TS_RESET:  tap_next = tms ? TS_RESET  : TS_IDLE;
      TS_IDLE:   tap_next = tms ? TS_SEL_DR : TS_IDLE;
      TS_SEL_DR: tap_next = tms ? TS_SEL_IR : TS_CAP_DR;
      TS_CAP_DR: tap_next = tms ? TS_EX1_DR : TS_SH_DR;
      TS_SH_DR:  tap_next = tms ? TS_EX1_DR : TS_SH_DR;
      TS_EX1_DR: tap_next = tms ? TS_UP_DR  : TS_PA_DR;
      TS_PA_DR:  tap_next = tms ? TS_EX2_DR : TS_PA_DR;
      TS_EX2_DR: tap_next = tms ? TS_UP_DR  : TS_SH_DR;
      TS_UP_DR:  tap_next = tms ? TS_SEL_DR : TS_IDLE;
      TS_SEL_IR: tap_next = tms ? TS_RESET  : TS_CAP_IR;
      TS_CAP_IR: tap_next = tms ? TS_EX1_IR : TS_SH_IR;
      TS_SH_IR:  tap_next = tms ? TS_EX1_IR : TS_SH_IR;
      TS_EX1_IR: tap_next = tms ? TS_UP_IR  : TS_PA_IR;
      TS_PA_IR:  tap_next = tms ? TS_EX2_IR : TS_PA_IR;
      TS_EX2_IR: tap_next = tms ? TS_UP_IR  : TS_SH_IR;
      TS_UP_IR:  tap_next = tms ? TS_SEL_DR : TS_IDLE;
      default:   tap_next = TS_RESET;
    endcase
  end

  // ****************************************
  // instruction and data registers
  // ****************************************
  logic [IR_LEN-1:0] ir_sh_reg;
  logic [IR_LEN-1:0] ir_reg;
  logic [ID_LEN-1:0] dr_sh_reg;
  logic              tdo_reg;
  logic              cmd_break_reg;
  logic              cmd_step_reg;
  logic              cmd_resume_reg;

  wire logic sel_id = (ir_reg == IR_IDCODE); // [RQ1]

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tap_reg <= TS_RESET;
      ir_sh_reg <= '0;
      ir_reg <= IR_RESET_VALUE;
      dr_sh_reg <= '0;
    end else if (tck_rise) begin
      tap_reg <= tap_next;
      if (tap_reg == TS_RESET) begin
        ir_reg <= IR_RESET_VALUE; // [RQ2]
      end
      if (tap_reg == TS_CAP_IR) begin
        ir_sh_reg <= IR_CAPTURE_PAT;
      end
      if (tap_reg == TS_SH_IR) begin
        ir_sh_reg <= {tdi, ir_sh_reg[IR_LEN-1:1]};
      end
      if (tap_reg == TS_UP_IR) begin
        ir_reg <= ir_sh_reg;
      end
      // capture reloads the constant, so shifted-in bits never persist
      if (tap_reg == TS_CAP_DR) begin
        dr_sh_reg <= sel_id ? ID_VALUE : '0; // [RQ3] [RQ15]
      end
      if (tap_reg == TS_SH_DR) begin
        dr_sh_reg <= sel_id ? {tdi, dr_sh_reg[ID_LEN-1:1]} : {{(ID_LEN-1){1'b0}}, tdi}; // [RQ15]
      end
    end
  end

  // data out changes on the falling test clock edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tdo_reg <= 1'b0;
    end else if (tck_fall) begin
      tdo_reg <= (tap_reg == TS_SH_IR) ? ir_sh_reg[0] : dr_sh_reg[0]; // [RQ1]
    end
  end

  wire logic shifting = (tap_reg == TS_SH_IR) || (tap_reg == TS_SH_DR);
  wire logic upd_ir   = tck_rise && (tap_reg == TS_UP_IR);

  // one-cycle command pulses decoded from a freshly loaded instruction
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmd_break_reg  <= 1'b0;
      cmd_step_reg   <= 1'b0;
      cmd_resume_reg <= 1'b0;
    end else begin
      cmd_break_reg  <= upd_ir && (ir_sh_reg == IR_BREAK);
      cmd_step_reg   <= upd_ir && (ir_sh_reg == IR_STEP);
      cmd_resume_reg <= upd_ir && (ir_sh_reg == IR_RESUME);
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      tdo_out[i]  = tdo_reg;
      tdo_oe_n[i] = ~(shifting && (grp == 2'(i))); // [RQ12]
    end
  end

  // ****************************************
  // debug mode strap and break logic
  // ****************************************
  function automatic logic in_range(input logic [CODE_AW-1:0] a, input logic [CODE_AW-1:0] lo,
                                    input logic [CODE_AW-1:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  logic       strap_done_reg;
  logic [1:0] strap_age_reg;
  logic       debug_mode_reg;
  logic       monitor_reg;
  logic       stepping_reg;

  wire logic code_hit = brk_cfg.code_en && core_dbg.fetch_valid &&
                        (brk_cfg.code_range ? in_range(core_dbg.fetch_addr, brk_cfg.code_lo, brk_cfg.code_hi)
                                            : (core_dbg.fetch_addr == brk_cfg.code_lo)); // [RQ5]
  wire logic ram_hit  = brk_cfg.ram_en && core_dbg.ram_valid &&
                        in_range(CODE_AW'(core_dbg.ram_addr), CODE_AW'(brk_cfg.ram_lo),
                                 CODE_AW'(brk_cfg.ram_hi)); // [RQ6]
  wire logic ext_hit  = cmd_break_reg || brk_pin; // [RQ8]
  wire logic step_hit = stepping_reg && core_dbg.step_done; // [RQ9]
  wire logic any_brk  = debug_mode_reg && !monitor_reg &&
                        (code_hit || ram_hit || core_dbg.brk_insn || ext_hit || step_hit); // [RQ4] [RQ7]

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      strap_done_reg <= 1'b0;
      strap_age_reg  <= '0;
      debug_mode_reg <= 1'b0;
      monitor_reg    <= 1'b0;
      stepping_reg   <= 1'b0;
    end else begin
      strap_age_reg  <= {strap_age_reg[0], 1'b1};
      // strap caught once; waits until the synchroniser holds a real pin sample, not its reset zero
      if (strap_age_reg[1] && !strap_done_reg) begin
        strap_done_reg <= 1'b1;
        debug_mode_reg <= brk_pin; // [RQ14] [RQ4]
      end
      if (any_brk) begin
        monitor_reg  <= 1'b1;
        stepping_reg <= 1'b0;
      end else if (monitor_reg && (cmd_resume_reg || cmd_step_reg)) begin
        monitor_reg  <= 1'b0;
        stepping_reg <= cmd_step_reg && brk_cfg.step_en; // [RQ9]
      end
    end
  end

  // ****************************************
  // monitor memory steering
  // ****************************************
  assign debug_mode      = debug_mode_reg;
  assign in_monitor      = monitor_reg; // [RQ11]
  assign core_halt       = monitor_reg;
  assign sel_monitor_rom = monitor_reg && core_dbg.fetch_valid; // [RQ10]
  assign sel_monitor_ram = monitor_reg && core_dbg.ram_valid; // [RQ10]

endmodule : debug_monitor_jtag_access

// ### tb/debug_monitor_properties.sv
// port relation checks of the debug access block
// assumes a bind onto the block top; one clock domain
`timescale 1ns/1ns
module debug_checker
  import debug_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [1:0] pin_select,
  input wire logic [2:0] tdo_oe_n,
  input wire logic       monitor_break_pin,
  input wire core_dbg_t  core_dbg,
  input wire brk_cfg_t   brk_cfg,
  input wire logic       debug_mode,
  input wire logic       core_halt,
  input wire logic       in_monitor,
  input wire logic       sel_monitor_rom,
  input wire logic       sel_monitor_ram
);
  // ********
  // helpers
  // ********
  wire logic       act = debug_mode && !in_monitor;
  wire logic [2:0] gm  = 3'h1 << ((pin_select == 2'h3) ? 2'h0 : pin_select);
  wire logic [15:0] fa = core_dbg.fetch_addr;
  wire logic [7:0] ra  = core_dbg.ram_addr;
  wire logic chit = core_dbg.fetch_valid && brk_cfg.code_en && (brk_cfg.code_range ?
    (fa >= brk_cfg.code_lo && fa <= brk_cfg.code_hi) : (fa == brk_cfg.code_lo));
  wire logic rhit = core_dbg.ram_valid && brk_cfg.ram_en && ra >= brk_cfg.ram_lo && ra <= brk_cfg.ram_hi;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence enter_s;
    ##1 in_monitor;
  endsequence
  // ********
  // properties
  // ********
  rom_route_a: assert property (sel_monitor_rom == (in_monitor && core_dbg.fetch_valid))
    else $error("monitor rom select wrong");
  ram_route_a: assert property (sel_monitor_ram == (in_monitor && core_dbg.ram_valid))
    else $error("monitor ram select wrong");
  halt_tracks_a: assert property (core_halt == in_monitor)
    else $error("core halt differs from monitor state");
  no_debug_a: assert property (!debug_mode |-> !in_monitor)
    else $error("monitor entered outside debug mode");
  insn_break_a: assert property (act && core_dbg.brk_insn |-> enter_s)
    else $error("break instruction missed");
  code_break_a: assert property (act && chit |-> enter_s)
    else $error("code breakpoint missed");
  ram_break_a: assert property (act && rhit |-> enter_s)
    else $error("ram breakpoint missed");
  pin_break_a: assert property (act && monitor_break_pin |-> ##[1:4] in_monitor)
    else $error("break pin missed");
  oe_group_a: assert property ((~tdo_oe_n & ~gm) == 3'h0)
    else $error("data out enabled on unselected group");
  mode_hold_a: assert property ($past(debug_mode) |-> debug_mode)
    else $error("debug mode dropped without reset");
endmodule : debug_checker
bind debug_monitor_jtag_access debug_checker debug_checker_inst (.*);

// ### tb/jtag_host_model.sv
// debugger host model for the test port of the selected pin group
// assumes the bench routes tck, tms, tdi to that group and its data out back
`timescale 1ns/1ns
module jtag_host_model (
  input  wire logic clk_sys,
  input  wire logic tdo,
  output logic      tck, // always driven by the host
  output logic      tms,
  output logic      tdi  // always driven by the host
);
  // ********
  // 320 ns test clock, standing low between frames
  // ********
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  task automatic half;
    repeat (4) @(negedge clk_sys);
  endtask : half
  // sampled just before the rise, while the shift state still holds
  task automatic bit_x(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    half();
    q = tdo;
    tck = 1'b1;
    half();
    tck = 1'b0;
  endtask : bit_x
  task automatic reset_tap;
    logic t;
    repeat (5) bit_x(1'b1, 1'b0, t);
  endtask : reset_tap
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] q);
    logic t;
    q = '0;
    bit_x(1'b0, 1'b0, t);
    bit_x(1'b1, 1'b0, t);
    if (ir)
      bit_x(1'b1, 1'b0, t);
    bit_x(1'b0, 1'b0, t);
    bit_x(1'b0, 1'b0, t);
    for (int i = 0; i < n; i++)
      bit_x(i == n - 1, din[i], q[i]);
    bit_x(1'b1, 1'b0, t);
    bit_x(1'b0, 1'b0, t);
  endtask : scan
endmodule : jtag_host_model

// ### tb/tb_top.sv
// self-checking bench of the debug access block
// assumes the host model in its own file and the checker bound to the top
`timescale 1ns/1ns
module tb_top;
  import debug_pkg::*;
  localparam int LIMIT = 40000;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [1:0]  pin_select = 2'h0;
  logic        monitor_break_pin = 1'b1;
  core_dbg_t   core_dbg = '0;
  brk_cfg_t    brk_cfg = '0;
  logic        tck, tms, tdi, tdo_last = 1'b0, seen_oe = 1'b0;
  logic [2:0]  tdo_out, tdo_oe_n;
  logic        debug_mode, core_halt, in_monitor, sel_rom, sel_ram;
  int          err_count = 0, checked = 0, cycles = 0;
  logic [31:0] q;
  wire logic [1:0] g  = (pin_select == 2'h3) ? 2'h0 : pin_select;
  wire logic [2:0] gm = 3'h1 << g;
  // released data line shows the inverse of its last driven level
  wire logic   tdo_w = tdo_oe_n[g] ? ~tdo_last : tdo_out[g];
  brk_cfg_t    cfgs[5] = '{'0, '{code_lo: 16'h1234, code_en: 1'b1, default: '0},
    '{code_lo: 16'h1000, code_hi: 16'h10FF, code_en: 1'b1, code_range: 1'b1, default: '0},
    '{ram_lo: 8'h20, ram_hi: 8'h2F, ram_en: 1'b1, default: '0},
    '{code_lo: 16'h1000, code_hi: 16'h10FF, code_en: 1'b1, code_range: 1'b1, default: '0}};
  core_dbg_t   dbgs[5] = '{'{brk_insn: 1'b1, default: '0}, '{fetch_addr: 16'h1234, fetch_valid: 1'b1, default: '0},
    '{fetch_addr: 16'h10FF, fetch_valid: 1'b1, default: '0}, '{ram_addr: 8'h20, ram_valid: 1'b1, default: '0},
    '{fetch_addr: 16'h1100, fetch_valid: 1'b1, default: '0}};
  logic        hit[5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  debug_monitor_jtag_access debug_monitor_jtag_access_inst (.clk_sys(clk_sys), .rst(rst), .pin_select(pin_select),
    .tck_pins(gm & {3{tck}}), .tms_pins(~gm | {3{tms}}), .tdi_pins({3{tdi}}), .tdo_out(tdo_out),
    .tdo_oe_n(tdo_oe_n), .monitor_break_pin(monitor_break_pin), .core_dbg(core_dbg), .brk_cfg(brk_cfg),
    .debug_mode(debug_mode), .core_halt(core_halt), .in_monitor(in_monitor), .sel_monitor_rom(sel_rom),
    .sel_monitor_ram(sel_ram));
  jtag_host_model jtag_host_model_inst (.clk_sys(clk_sys), .tdo(tdo_w), .tck(tck), .tms(tms), .tdi(tdi));
  always #20 clk_sys = ~clk_sys;
  // ********
  // tasks
  // ********
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wmon(input logic e);
    for (int n = 0; n < 40 && in_monitor !== e; n++)
      @(negedge clk_sys);
    chk(in_monitor, e);
  endtask : wmon
  task automatic cmd(input logic [3:0] c);
    jtag_host_model_inst.scan(1'b1, IR_LEN, 32'(c), q);
  endtask : cmd
  task automatic do_reset(input logic strap);
    rst = 1'b1;
    monitor_break_pin = strap;
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    repeat (3) @(negedge clk_sys);
    monitor_break_pin = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask : do_reset
  task automatic s_id;
    for (int k = 0; k < 3; k++) begin
      pin_select = 2'(k);
      seen_oe = 1'b0;
      jtag_host_model_inst.reset_tap();
      jtag_host_model_inst.scan(1'b0, ID_LEN, 32'h0000_0000, q);
      chk(q, ID_VALUE);
      cmd(IR_BYPASS);
      cmd(IR_IDCODE);
      jtag_host_model_inst.scan(1'b0, ID_LEN, 32'hFFFF_FFFF, q);
      chk(q, ID_VALUE);
      jtag_host_model_inst.scan(1'b0, ID_LEN, 32'h0000_0000, q);
      chk(q, ID_VALUE);
      chk(seen_oe, 1'b1);
    end
  endtask : s_id
  task automatic s_hw;
    for (int k = 0; k < 5; k++) begin
      brk_cfg = cfgs[k];
      core_dbg = dbgs[k];
      repeat (6) @(negedge clk_sys);
      chk(in_monitor, hit[k]);
      chk({sel_rom, sel_ram}, {2{hit[k]}} & {core_dbg.fetch_valid, core_dbg.ram_valid});
      core_dbg = '0;
      cmd(IR_RESUME);
      wmon(1'b0);
    end
  endtask : s_hw
  task automatic s_step;
    brk_cfg = '{step_en: 1'b1, default: '0};
    cmd(IR_BREAK);
    wmon(1'b1);
    cmd(IR_STEP);
    wmon(1'b0);
    core_dbg = '{step_done: 1'b1, default: '0};
    wmon(1'b1);
    core_dbg = '0;
    brk_cfg = '0;
    cmd(IR_RESUME);
    wmon(1'b0);
  endtask : s_step
  task automatic s_pin;
    monitor_break_pin = 1'b1;
    wmon(1'b1);
    monitor_break_pin = 1'b0;
    cmd(IR_RESUME);
    wmon(1'b0);
  endtask : s_pin
  // ********
  // main sequence and hang limit
  // ********
  always @(posedge clk_sys) begin
    cycles++;
    if (!tdo_oe_n[g]) begin
      seen_oe <= 1'b1;
      tdo_last <= tdo_out[g];
    end
    if (cycles == LIMIT) begin
      err_count++;
      stop_test();
    end
  end
  initial begin
    do_reset(1'b1);
    chk(debug_mode, 1'b1);
    wmon(1'b1);
    cmd(IR_RESUME);
    wmon(1'b0);
    s_id();
    s_hw();
    s_step();
    s_pin();
    do_reset(1'b0);
    chk(debug_mode, 1'b0);
    core_dbg = '{brk_insn: 1'b1, default: '0};
    cmd(IR_BREAK);
    chk(in_monitor, 1'b0);
    stop_test();
  end
endmodule : tb_top
